//--- hdl/pin_function_select_mux.sv
// Pin function multiplexer: selectors, port latches, input routing, wake.
// Assumes synchronous pin inputs and a single-cycle register port master.
//
// Behaviour
// R1: Port E pins 7..4 are GPIO unless code 11 selects segments 32..29.
// R2: Port F pins 3..0 are GPIO unless code 11 selects segments 20..17.
// R3: Port F pins 7..4 are GPIO unless code 11 selects segments 24..21.
// R4: Port G pins 2..0: GPIO, code 10 bias/cap pins, 11 segments 45..43.
// R5: Timer3 capture comes from PA4, or PC2 when its select bit is set.
// R6: Timer2 capture comes from PA3, or PC0 when its select bit is set.
// R7: Timer3 external clock comes from PC3, or PA7 when selected.
// R8: Standard timer clock from PA1, or PA6; unused bits read zero.
// R9: Serial chip select comes from PA4, or PC4, on both variants.
// R10: Serial data in comes from PA6, or PB3 when selected.
// R11: Serial clock from PA5, or PB2 small variant, PC4 large variant.
// R12: Small variant only: UART receive from PA6 or PC4; else bits zero.
// R13: Reset sets every port data and direction bit to one.
// R14: A pin turned output before any data write drives high.
// R15: Direction is written as a byte or changed by single bit commands.
// R16: A bit command reads the whole port, modifies one bit, writes back.
// R17: In sleep or idle, falling edge on enabled port A pin wakes.
// R18: A peripheral input follows only the pin its select bit points to.
//
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pin_function_select_mux
    import pin_function_select_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int N_PORTS       = 7
) (
    // Clock and reset
    input  wire logic                                 clock,
    input  wire logic                                 rst,
    // Register port
    input  wire logic [pin_function_select_pkg::ADDR_W-1:0] addr,
    input  wire logic [pin_function_select_pkg::DATA_W-1:0] wdata,
    input  wire logic                                 wr,
    input  wire logic                                 rd,
    output logic      [pin_function_select_pkg::DATA_W-1:0] rdata,
    // Pins
    input  wire logic [N_PORTS*8-1:0]                 pin_in,
    output logic      [N_PORTS*8-1:0]                 pin_out,
    output logic      [N_PORTS*8-1:0]                 pin_oe,
    // LCD driver side
    input  wire logic [3:0]                           lcd_seg_pe,
    input  wire logic [7:0]                           lcd_seg_pf,
    input  wire logic [2:0]                           lcd_seg_pg,
    output logic                                      lcd_bias_node_en,
    output logic                                      lcd_pump_cap_second_en,
    output logic                                      lcd_pump_cap_first_en,
    // Routed peripheral inputs
    output logic                                      timer3_capture_input,
    output logic                                      timer2_capture_input,
    output logic                                      timer3_ext_clock,
    output logic                                      std_timer_ext_clock,
    output logic                                      serial_b_chip_select,
    output logic                                      serial_b_data_in,
    output logic                                      serial_b_clock,
    output logic                                      uart_rx_input,
    // Power management
    input  wire logic                                 sleep_or_idle,
    output logic                                      wake_req
);
    import pin_function_select_pkg::*;

    localparam logic [7:0] SERIAL_MASK = LARGE_VARIANT ? SERIAL_LARGE_MASK : SERIAL_SMALL_MASK;

    // Address decode for the per-port register banks
    function automatic logic bank_hit(input logic [7:0] a, input logic [7:0] base);
        bank_hit = (a[7:3] == base[7:3]) && (int'(a[2:0]) < N_PORTS);
    endfunction

    function automatic logic is_segment(input logic [1:0] code);
        is_segment = (code == CODE_SEGMENT);
    endfunction

    // Register state
    logic [7:0]   pe_high_sel;
    logic [7:0]   pf_low_sel;
    logic [7:0]   pf_high_sel;
    logic [7:0]   pg_sel;
    logic [7:0]   timer_src;
    logic [7:0]   serial_src;
    logic [7:0]   wake_en;
    logic [7:0]   data_reg [N_PORTS];
    logic [7:0]   ctrl_reg [N_PORTS];
    bitop_state_e state;
    logic [7:0]   op;
    logic [7:0]   next_pe_high_sel;
    logic [7:0]   next_pf_low_sel;
    logic [7:0]   next_pf_high_sel;
    logic [7:0]   next_pg_sel;
    logic [7:0]   next_timer_src;
    logic [7:0]   next_serial_src;
    logic [7:0]   next_wake_en;
    logic [7:0]   next_data_reg [N_PORTS];
    logic [7:0]   next_ctrl_reg [N_PORTS];
    bitop_state_e next_state;
    logic [7:0]   next_op;
    logic [7:0]   next_rdata;
    logic [7:0]   modified;
    logic [7:0]   source_byte;
    logic [2:0]   op_port;
    logic [7:0]   op_mask;

    assign op_port = op[BITOP_PORT_LSB+:3];
    assign op_mask = 8'h01 << op[BITOP_BIT_LSB+:3];

    // Register file and bit command sequencer
    always_comb begin
        next_pe_high_sel = pe_high_sel;
        next_pf_low_sel  = pf_low_sel;
        next_pf_high_sel = pf_high_sel;
        next_pg_sel      = pg_sel;
        next_timer_src   = timer_src;
        next_serial_src  = serial_src;
        next_wake_en     = wake_en;
        next_data_reg    = data_reg;
        next_ctrl_reg    = ctrl_reg;
        next_state       = state;
        next_op          = op;
        next_rdata       = 8'h00;
        source_byte      = 8'h00;
        modified         = 8'h00;
        if (wr) begin
            case (addr)
                PE_HIGH_SEL_ADDR: next_pe_high_sel = wdata;
                PF_LOW_SEL_ADDR:  next_pf_low_sel  = wdata;
                PF_HIGH_SEL_ADDR: next_pf_high_sel = wdata;
                PG_SEL_ADDR:      next_pg_sel      = wdata & PG_SEL_MASK;
                TIMER_SRC_ADDR:   next_timer_src   = wdata & TIMER_SRC_MASK; // R8
                SERIAL_SRC_ADDR:  next_serial_src  = wdata & SERIAL_MASK; // R12
                WAKE_EN_ADDR:     next_wake_en     = wdata; // R17
                BITOP_ADDR: begin
                    if (state == ST_IDLE) begin
                        next_op    = wdata;
                        next_state = ST_MODIFY;
                    end
                end
                default: begin
                    if (bank_hit(addr, DATA_BASE_ADDR)) begin
                        next_data_reg[addr[2:0]] = wdata;
                    end
                    if (bank_hit(addr, CTRL_BASE_ADDR)) begin
                        next_ctrl_reg[addr[2:0]] = wdata; // R15
                    end
                end
            endcase
        end
        case (state)
            ST_IDLE: begin
            end
            ST_MODIFY: begin
                next_state = ST_IDLE;
                if (int'(op_port) < N_PORTS) begin
                    // Whole port read, one bit changed, whole byte written back
                    source_byte = op[BITOP_CTRL_BIT] ? ctrl_reg[op_port]
                                                     : pin_in[int'(op_port)*8+:8]; // R16
                    modified = op[BITOP_SET_BIT] ? (source_byte | op_mask)
                                                 : (source_byte & ~op_mask); // R16
                    if (op[BITOP_CTRL_BIT]) begin
                        next_ctrl_reg[op_port] = modified; // R15
                    end else begin
                        next_data_reg[op_port] = modified;
                    end
                end
            end
            default: next_state = ST_IDLE;
        endcase
        if (rd) begin
            case (addr)
                PE_HIGH_SEL_ADDR: next_rdata = pe_high_sel;
                PF_LOW_SEL_ADDR:  next_rdata = pf_low_sel;
                PF_HIGH_SEL_ADDR: next_rdata = pf_high_sel;
                PG_SEL_ADDR:      next_rdata = pg_sel;
                TIMER_SRC_ADDR:   next_rdata = timer_src;
                SERIAL_SRC_ADDR:  next_rdata = serial_src;
                WAKE_EN_ADDR:     next_rdata = wake_en;
                STATUS_ADDR:      next_rdata = {7'h00, state == ST_MODIFY};
                default: begin
                    if (bank_hit(addr, DATA_BASE_ADDR)) begin
                        next_rdata = pin_in[int'(addr[2:0])*8+:8];
                    end
                    if (bank_hit(addr, CTRL_BASE_ADDR)) begin
                        next_rdata = ctrl_reg[addr[2:0]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pe_high_sel <= SEL_RESET;
            pf_low_sel  <= SEL_RESET;
            pf_high_sel <= SEL_RESET;
            pg_sel      <= SEL_RESET;
            timer_src   <= SEL_RESET;
            serial_src  <= SEL_RESET;
            wake_en     <= WAKE_EN_RESET;
            for (int i = 0; i < N_PORTS; i++) begin
                data_reg[i] <= PORT_RESET; // R13
                ctrl_reg[i] <= PORT_RESET; // R13
            end
            state <= ST_IDLE;
            op    <= 8'h00;
            rdata <= 8'h00;
        end else begin
            pe_high_sel <= next_pe_high_sel;
            pf_low_sel  <= next_pf_low_sel;
            pf_high_sel <= next_pf_high_sel;
            pg_sel      <= next_pg_sel;
            timer_src   <= next_timer_src;
            serial_src  <= next_serial_src;
            wake_en     <= next_wake_en;
            data_reg    <= next_data_reg;
            ctrl_reg    <= next_ctrl_reg;
            state       <= next_state;
            op          <= next_op;
            rdata       <= next_rdata;
        end
    end

    // Pin drivers: GPIO latch by default, LCD function where selected
    genvar gp;
    genvar gb;
    generate
        for (gp = 0; gp < N_PORTS; gp++) begin : g_port
            for (gb = 0; gb < 8; gb++) begin : g_pin
                logic [1:0] code;
                logic       seg_val;
                if (gp == PORT_E && gb >= 4) begin : g_e
                    assign code    = pe_high_sel[2*(gb-4)+:2]; // R1
                    assign seg_val = lcd_seg_pe[gb-4];
                end else if (gp == PORT_F && gb < 4) begin : g_fl
                    assign code    = pf_low_sel[2*gb+:2]; // R2
                    assign seg_val = lcd_seg_pf[gb];
                end else if (gp == PORT_F) begin : g_fh
                    assign code    = pf_high_sel[2*(gb-4)+:2]; // R3
                    assign seg_val = lcd_seg_pf[gb];
                end else if (gp == PORT_G && gb < 3) begin : g_g
                    assign code    = pg_sel[2*gb+:2]; // R4
                    assign seg_val = lcd_seg_pg[gb];
                end else begin : g_plain
                    assign code    = 2'b00;
                    assign seg_val = 1'b0;
                end
                always_comb begin
                    if (is_segment(code)) begin
                        pin_out[gp*8+gb] = seg_val;
                        pin_oe[gp*8+gb]  = 1'b1;
                    end else if (gp == PORT_G && code == CODE_ANALOG) begin
                        pin_out[gp*8+gb] = 1'b0; // R4
                        pin_oe[gp*8+gb]  = 1'b0;
                    end else begin
                        pin_out[gp*8+gb] = data_reg[gp][gb]; // R14
                        pin_oe[gp*8+gb]  = ~ctrl_reg[gp][gb];
                    end
                end
            end
        end
    endgenerate

    assign lcd_bias_node_en       = (pg_sel[5:4] == CODE_ANALOG); // R4
    assign lcd_pump_cap_second_en = (pg_sel[3:2] == CODE_ANALOG);
    assign lcd_pump_cap_first_en  = (pg_sel[1:0] == CODE_ANALOG);

    // Peripheral input routing and port A wake detection
    logic [7:0] prev_pa;
    logic [7:0] next_prev_pa;
    logic       next_wake_req;
    logic       next_timer3_capture_input;
    logic       next_timer2_capture_input;
    logic       next_timer3_ext_clock;
    logic       next_std_timer_ext_clock;
    logic       next_serial_b_chip_select;
    logic       next_serial_b_data_in;
    logic       next_serial_b_clock;
    logic       next_uart_rx_input;

    always_comb begin
        next_timer3_capture_input = timer_src[TIMER3_CAPTURE_BIT] ? pin_in[PORT_C*8+2]
                                                                  : pin_in[PORT_A*8+4]; // R5
        next_timer2_capture_input = timer_src[TIMER2_CAPTURE_BIT] ? pin_in[PORT_C*8+0]
                                                                  : pin_in[PORT_A*8+3]; // R6
        next_timer3_ext_clock     = timer_src[TIMER3_CLOCK_BIT] ? pin_in[PORT_A*8+7]
                                                                : pin_in[PORT_C*8+3]; // R7
        next_std_timer_ext_clock  = timer_src[STD_CLOCK_BIT] ? pin_in[PORT_A*8+6]
                                                             : pin_in[PORT_A*8+1]; // R8
        next_serial_b_chip_select = serial_src[SERIAL_CS_BIT] ? pin_in[PORT_C*8+4]
                                                              : pin_in[PORT_A*8+4]; // R9
        next_serial_b_data_in     = serial_src[SERIAL_DIN_BIT] ? pin_in[PORT_B*8+3]
                                                               : pin_in[PORT_A*8+6]; // R10
        if (!serial_src[SERIAL_CLK_BIT]) begin
            next_serial_b_clock = pin_in[PORT_A*8+5]; // R18
        end else if (LARGE_VARIANT) begin
            next_serial_b_clock = pin_in[PORT_C*8+4]; // R11
        end else begin
            next_serial_b_clock = pin_in[PORT_B*8+2]; // R11
        end
        next_uart_rx_input = serial_src[UART_RX_BIT] ? pin_in[PORT_C*8+4]
                                                     : pin_in[PORT_A*8+6]; // R12
        next_prev_pa  = pin_in[PORT_A*8+:8];
        next_wake_req = sleep_or_idle && |(prev_pa & ~pin_in[PORT_A*8+:8] & wake_en); // R17
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            timer3_capture_input <= 1'b0;
            timer2_capture_input <= 1'b0;
            timer3_ext_clock     <= 1'b0;
            std_timer_ext_clock  <= 1'b0;
            serial_b_chip_select <= 1'b0;
            serial_b_data_in     <= 1'b0;
            serial_b_clock       <= 1'b0;
            uart_rx_input        <= 1'b0;
            prev_pa              <= 8'h00;
            wake_req             <= 1'b0;
        end else begin
            timer3_capture_input <= next_timer3_capture_input;
            timer2_capture_input <= next_timer2_capture_input;
            timer3_ext_clock     <= next_timer3_ext_clock;
            std_timer_ext_clock  <= next_std_timer_ext_clock;
            serial_b_chip_select <= next_serial_b_chip_select;
            serial_b_data_in     <= next_serial_b_data_in;
            serial_b_clock       <= next_serial_b_clock;
            uart_rx_input        <= next_uart_rx_input;
            prev_pa              <= next_prev_pa;
            wake_req             <= next_wake_req;
        end
    end

    // Checks
    chk_pe_segment_drive: assert property (@(posedge clock) disable iff (rst) // R1
        (pe_high_sel[7:6] == CODE_SEGMENT) |->
            (pin_oe[PORT_E*8+7] && pin_out[PORT_E*8+7] == lcd_seg_pe[3]))
        else $error("port E pin 7 not driving its segment");

    chk_pf_low_gpio: assert property (@(posedge clock) disable iff (rst) // R2
        (pf_low_sel[7:6] != CODE_SEGMENT) |->
            (pin_out[PORT_F*8+3] == data_reg[PORT_F][3]
             && pin_oe[PORT_F*8+3] == !ctrl_reg[PORT_F][3]))
        else $error("port F pin 3 not acting as GPIO");

    chk_pf_high_segment: assert property (@(posedge clock) disable iff (rst) // R3
        (pf_high_sel[1:0] == CODE_SEGMENT) |->
            (pin_oe[PORT_F*8+4] && pin_out[PORT_F*8+4] == lcd_seg_pf[4]))
        else $error("port F pin 4 not driving its segment");

    chk_pg_bias_pin: assert property (@(posedge clock) disable iff (rst) // R4
        (pg_sel[5:4] == CODE_ANALOG) |-> (lcd_bias_node_en && !pin_oe[PORT_G*8+2]))
        else $error("port G pin 2 not released to bias node");

    chk_capture_route: assert property (@(posedge clock) disable iff (rst) // R5
        !$past(rst) |-> timer3_capture_input == ($past(timer_src[TIMER3_CAPTURE_BIT])
            ? $past(pin_in[PORT_C*8+2]) : $past(pin_in[PORT_A*8+4])))
        else $error("timer3 capture routed from wrong pin");

    chk_clock_route: assert property (@(posedge clock) disable iff (rst) // R7
        (!$past(rst) && !$past(timer_src[TIMER3_CLOCK_BIT])) |->
            timer3_ext_clock == $past(pin_in[PORT_C*8+3]))
        else $error("timer3 clock not taken from port C pin 3");

    chk_serial_clock: assert property (@(posedge clock) disable iff (rst) // R11
        (!$past(rst) && $past(serial_src[SERIAL_CLK_BIT])) |-> serial_b_clock ==
            (LARGE_VARIANT ? $past(pin_in[PORT_C*8+4]) : $past(pin_in[PORT_B*8+2])))
        else $error("serial clock routed from wrong pin");

    chk_serial_mask: assert property (@(posedge clock) disable iff (rst) // R12
        (serial_src & ~SERIAL_MASK) == 8'h00 && (timer_src & ~TIMER_SRC_MASK) == 8'h00)
        else $error("unimplemented select bit set");

    chk_reset_ones: assert property (@(posedge clock) // R13
        (!rst && $past(rst)) |-> (data_reg[PORT_A] == PORT_RESET && ctrl_reg[PORT_G] == PORT_RESET))
        else $error("port latch not all ones after reset");

    chk_bitop_rmw: assert property (@(posedge clock) disable iff (rst) // R16
        (wr && addr == BITOP_ADDR && state == ST_IDLE && wdata[BITOP_CTRL_BIT]
         && !wdata[BITOP_SET_BIT] && wdata[5:3] == 3'(PORT_B)) |->
            ##2 (ctrl_reg[PORT_B] == ($past(ctrl_reg[PORT_B], 1) & ~(8'h01 << $past(wdata[2:0], 2)))))
        else $error("bit clear did not rewrite the direction byte");

    chk_wake_edge: assert property (@(posedge clock) disable iff (rst) // R17
        (sleep_or_idle && wake_en[0] && prev_pa[0] && !pin_in[PORT_A*8]) |=> wake_req)
        else $error("falling edge on port A pin 0 did not wake");

endmodule

`default_nettype wire

//--- hdl/pin_function_select_pkg.sv
// Constants for the pin function select multiplexer.
// Assumes an 8-bit register port and ports A to G with eight pins each.
package pin_function_select_pkg;

    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Port numbering within the flattened pin vectors
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_D = 3;
    localparam int PORT_E = 4;
    localparam int PORT_F = 5;
    localparam int PORT_G = 6;

    // Register offsets
    localparam logic [7:0] PE_HIGH_SEL_ADDR = 8'h00;
    localparam logic [7:0] PF_LOW_SEL_ADDR  = 8'h01;
    localparam logic [7:0] PF_HIGH_SEL_ADDR = 8'h02;
    localparam logic [7:0] PG_SEL_ADDR      = 8'h03;
    localparam logic [7:0] TIMER_SRC_ADDR   = 8'h04;
    localparam logic [7:0] SERIAL_SRC_ADDR  = 8'h05;
    localparam logic [7:0] WAKE_EN_ADDR     = 8'h06;
    localparam logic [7:0] BITOP_ADDR       = 8'h07;
    localparam logic [7:0] STATUS_ADDR      = 8'h08;
    localparam logic [7:0] DATA_BASE_ADDR   = 8'h10;
    localparam logic [7:0] CTRL_BASE_ADDR   = 8'h18;

    // Implemented bits of the port G, timer and serial selector registers
    localparam logic [7:0] PG_SEL_MASK       = 8'h3F;
    localparam logic [7:0] TIMER_SRC_MASK    = 8'hC9;
    localparam logic [7:0] SERIAL_SMALL_MASK = 8'h74;
    localparam logic [7:0] SERIAL_LARGE_MASK = 8'h70;

    // Reset values
    localparam logic [7:0] SEL_RESET     = 8'h00;
    localparam logic [7:0] WAKE_EN_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET    = 8'hFF;

    // Source select bit positions
    localparam int TIMER3_CAPTURE_BIT = 7;
    localparam int TIMER2_CAPTURE_BIT = 6;
    localparam int TIMER3_CLOCK_BIT   = 3;
    localparam int STD_CLOCK_BIT      = 0;
    localparam int SERIAL_CS_BIT      = 6;
    localparam int SERIAL_DIN_BIT     = 5;
    localparam int SERIAL_CLK_BIT     = 4;
    localparam int UART_RX_BIT        = 2;

    // Bit operation command fields
    localparam int BITOP_SET_BIT  = 7;
    localparam int BITOP_CTRL_BIT = 6;
    localparam int BITOP_PORT_LSB = 3;
    localparam int BITOP_BIT_LSB  = 0;
    localparam int STATUS_BUSY    = 0;

    // Pin function codes
    localparam logic [1:0] CODE_SEGMENT = 2'b11;
    localparam logic [1:0] CODE_ANALOG  = 2'b10;

    typedef enum logic {ST_IDLE, ST_MODIFY} bitop_state_e;

endpackage

//--- verification/tb_top.sv
// Self-checking bench for the pin function multiplexer, large variant.
// Assumes the package offsets and a single-cycle register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pin_function_select_pkg::*;
    logic        clock = 0, rst = 1, wr = 0, rd = 0, sleep_or_idle = 0;
    logic [7:0]  addr = 0, wdata = 0, t, r [4];
    logic [55:0] pin_in = 0, eo, xo;
    logic [3:0]  lcd_seg_pe = 0;
    logic [7:0]  lcd_seg_pf = 0, xr;
    logic [2:0]  lcd_seg_pg = 0;
    wire  [7:0]  rdata, route;
    wire  [55:0] pin_out, pin_oe;
    wire  [2:0]  en;
    wire         wake_req;
    integer      num_errors = 0, checks = 0, seed = 3, i, j;
    pin_function_select_mux pin_function_select_mux_i (
        .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .lcd_seg_pe(lcd_seg_pe), .lcd_seg_pf(lcd_seg_pf), .lcd_seg_pg(lcd_seg_pg),
        .lcd_bias_node_en(en[2]), .lcd_pump_cap_second_en(en[1]),
        .lcd_pump_cap_first_en(en[0]), .timer3_capture_input(route[7]),
        .timer2_capture_input(route[6]), .timer3_ext_clock(route[5]),
        .std_timer_ext_clock(route[4]), .serial_b_chip_select(route[3]),
        .serial_b_data_in(route[2]), .serial_b_clock(route[1]),
        .uart_rx_input(route[0]), .sleep_or_idle(sleep_or_idle), .wake_req(wake_req));
    initial forever #20 clock = ~clock;
    task automatic chk(input logic [55:0] got, want);
        checks++;
        if (got !== want) begin
            num_errors++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, want);
        end
    endtask
    task automatic wrr(input logic [7:0] a, d);
        @(posedge clock);
        wr <= 1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 0;
        #1;
    endtask
    task automatic rdr(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        rd <= 1;
        addr <= a;
        @(posedge clock);
        rd <= 0;
        #1 d = rdata;
    endtask
    task automatic close_out;
        if (num_errors == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge clock);
        rst <= 0;
        #1 chk(pin_oe, 0);
        for (i = 0; i < 7; i++) begin
            rdr(CTRL_BASE_ADDR + i[7:0], t);
            chk(t, 8'hFF);
        end
        // Input source routing
        for (i = 0; i < 8; i++) begin
            t = $random(seed);
            wrr(TIMER_SRC_ADDR, t);
            wrr(SERIAL_SRC_ADDR, t);
            @(posedge clock);
            pin_in <= 56'({$random(seed), $random(seed)});
            repeat (2) @(posedge clock);
            #1 xr = {t[7] ? pin_in[18] : pin_in[4], t[6] ? pin_in[16] : pin_in[3],
                     t[3] ? pin_in[7] : pin_in[19], t[0] ? pin_in[6] : pin_in[1],
                     t[6] ? pin_in[20] : pin_in[4], t[5] ? pin_in[11] : pin_in[6],
                     t[4] ? pin_in[20] : pin_in[5], pin_in[6]};
            chk(route, xr);
            rdr(TIMER_SRC_ADDR, r[0]);
            chk(r[0], t & TIMER_SRC_MASK);
            rdr(SERIAL_SRC_ADDR, r[0]);
            chk(r[0], t & SERIAL_LARGE_MASK);
        end
        // Pin function selection
        for (i = 0; i < 8; i++) begin
            @(posedge clock);
            lcd_seg_pe <= 4'($random(seed));
            lcd_seg_pf <= 8'($random(seed));
            lcd_seg_pg <= 3'($random(seed));
            for (j = 0; j < 4; j++) begin
                r[j] = $random(seed);
                wrr(PE_HIGH_SEL_ADDR + j[7:0], r[j]);
            end
            eo = 0;
            xo = 0;
            for (j = 0; j < 4; j++) begin
                eo[36+j] = r[0][2*j+:2] == CODE_SEGMENT;
                xo[36+j] = lcd_seg_pe[j];
                eo[40+j] = r[1][2*j+:2] == CODE_SEGMENT;
                xo[40+j] = lcd_seg_pf[j];
                eo[44+j] = r[2][2*j+:2] == CODE_SEGMENT;
                xo[44+j] = lcd_seg_pf[4+j];
                if (j < 3) begin
                    eo[48+j] = r[3][2*j+:2] == CODE_SEGMENT;
                    xo[48+j] = lcd_seg_pg[j];
                end
            end
            chk(pin_oe, eo);
            chk(pin_out & eo, xo & eo);
            chk(en, {r[3][5:4] == 2'b10, r[3][3:2] == 2'b10, r[3][1:0] == 2'b10});
            rdr(PG_SEL_ADDR, t);
            chk(t, r[3] & PG_SEL_MASK);
        end
        // Direction byte and single bit commands on port B
        wrr(CTRL_BASE_ADDR + 8'h01, 8'h00);
        chk(pin_oe[15:8], 8'hFF);
        chk(pin_out[15:8], 8'hFF);
        wrr(BITOP_ADDR, 8'hCB);
        @(posedge clock);
        #1 chk(pin_oe[15:8], 8'hF7);
        rdr(STATUS_ADDR, t);
        chk(t, 8'h00);
        wrr(BITOP_ADDR, 8'h4B);
        @(posedge clock);
        #1 chk(pin_oe[15:8], 8'hFF);
        wrr(BITOP_ADDR, 8'h08);
        @(posedge clock);
        #1 chk(pin_out[15:8], pin_in[15:8] & 8'hFE);
        rdr(DATA_BASE_ADDR + 8'h01, t);
        chk(t, pin_in[15:8]);
        @(posedge clock);
        #1 chk(rdata, 8'h00);
        // Wake on falling edge: enabled, awake, pin not enabled
        for (j = 0; j < 3; j++) begin
            wrr(WAKE_EN_ADDR, j == 2 ? 8'h02 : 8'h01);
            @(posedge clock);
            pin_in[0] <= 1;
            sleep_or_idle <= j != 1;
            repeat (2) @(posedge clock);
            pin_in[0] <= 0;
            @(posedge clock);
            #1 chk(wake_req, j == 0);
        end
        rdr(WAKE_EN_ADDR, t);
        chk(t, 8'h02);
        close_out();
    end
endmodule
`default_nettype wire
